// ### core/slbsc_ctrl.sv
// External SRAM controller for coefficients and the circular line buffer
`timescale 1ns/1ps
module slbsc_ctrl (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	// Configuration
	input wire slbsc_pkg::slbsc_mem_e mem_size,
	input wire slbsc_pkg::slbsc_mode_e acc_mode,
	input wire logic dpi_600,
	input wire logic [1:0] drive_cfg,
	input wire logic scanning,
	// Coefficient side
	input wire logic [15:0] pix_index,
	output slbsc_pkg::slbsc_coef_s coef,
	output logic coef_valid,
	// Pixel write side
	input wire logic [11:0] pix_data,
	input wire logic pix_valid,
	output logic pix_ready,
	// Host read side
	output logic [7:0] host_data,
	output logic host_valid,
	input wire logic host_ready,
	// Buffer state
	output logic buf_full,
	output logic buf_empty,
	// SRAM pins
	output slbsc_pkg::slbsc_sram_s sram,
	input wire logic [7:0] sram_din
);
	logic [2:0] phase_reg;
	logic [7:0] din_s1_reg;
	logic [7:0] din_s2_reg;
	logic [17:0] wptr_reg;
	logic [17:0] rptr_reg;
	logic [18:0] count_reg;
	logic [11:0] samp_reg;
	logic samp_hi_done_reg;
	logic host_lo_reg;
	logic [7:0] coef_hi_reg;
	slbsc_pkg::slbsc_acc_e acc;
	logic [17:0] base;
	logic [17:0] top;
	logic [18:0] cap;
	logic [17:0] lin_addr;
	logic do_access;
	logic acc_first;
	logic [7:0] wr_byte;

	// Slot table per schedule and phase
	function automatic slbsc_pkg::slbsc_acc_e slot_kind(input slbsc_pkg::slbsc_mode_e m,
			input logic [2:0] ph);
		slbsc_pkg::slbsc_acc_e k;
		k = slbsc_pkg::SLBSC_ACC_IDLE;
		case (m)
			slbsc_pkg::SLBSC_M8_4: begin
				// Two clocks per access
				case (ph[2:1])
					2'h0: k = slbsc_pkg::SLBSC_ACC_OFS;
					2'h1: k = slbsc_pkg::SLBSC_ACC_GAIN;
					2'h2: k = slbsc_pkg::SLBSC_ACC_WR_LO;
					default: k = slbsc_pkg::SLBSC_ACC_HRD_LO;
				endcase
			end
			slbsc_pkg::SLBSC_M8_8: begin
				// One-clock reads, four host slots
				case (ph)
					3'h0: k = slbsc_pkg::SLBSC_ACC_OFS;
					3'h1: k = slbsc_pkg::SLBSC_ACC_GAIN;
					3'h2, 3'h3: k = slbsc_pkg::SLBSC_ACC_WR_LO;
					default: k = slbsc_pkg::SLBSC_ACC_HRD_LO;
				endcase
			end
			slbsc_pkg::SLBSC_M12_4: begin
				// Host slot reused for the second byte write
				case (ph[2:1])
					2'h0: k = slbsc_pkg::SLBSC_ACC_OFS;
					2'h1: k = slbsc_pkg::SLBSC_ACC_GAIN;
					2'h2: k = slbsc_pkg::SLBSC_ACC_WR_HI;
					default: k = slbsc_pkg::SLBSC_ACC_WR_LO;
				endcase
			end
			default: begin
				// Full duplex twelve bit
				case (ph)
					3'h0: k = slbsc_pkg::SLBSC_ACC_OFS;
					3'h1: k = slbsc_pkg::SLBSC_ACC_GAIN;
					3'h2: k = slbsc_pkg::SLBSC_ACC_HRD_HI;
					3'h3: k = slbsc_pkg::SLBSC_ACC_HRD_LO;
					3'h4, 3'h5: k = slbsc_pkg::SLBSC_ACC_WR_HI;
					default: k = slbsc_pkg::SLBSC_ACC_WR_LO;
				endcase
			end
		endcase
		return k;
	endfunction

	// Wrap a pointer at the top of memory back to the buffer base
	function automatic logic [17:0] ptr_inc(input logic [17:0] p, input logic [17:0] t,
			input logic [17:0] b);
		return (p >= t) ? b : p + 18'h00001;
	endfunction

	// Region bounds
	always_comb begin
		base = dpi_600 ? slbsc_pkg::SLBSC_COEF_END_600 : slbsc_pkg::SLBSC_COEF_END_300;
		case (mem_size)
			slbsc_pkg::SLBSC_MEM_64K: top = slbsc_pkg::SLBSC_TOP_64K;
			slbsc_pkg::SLBSC_MEM_128K: top = slbsc_pkg::SLBSC_TOP_128K;
			default: top = slbsc_pkg::SLBSC_TOP_256K;
		endcase
		cap = {1'b0, top} - {1'b0, base} + 19'h00001;
	end

	// Current slot; a two-clock slot is one access spanning both clocks
	always_comb begin
		acc = slot_kind(acc_mode, phase_reg);
	end

	// Pixel period counter, free running
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase_reg <= 3'h0;
		end else if (clk_en) begin
			phase_reg <= (phase_reg == slbsc_pkg::SLBSC_PHASE_LAST) ? 3'h0 : phase_reg + 3'h1;
		end
	end

	// Data pins come from outside; two stages before use
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			din_s1_reg <= 8'h00;
			din_s2_reg <= 8'h00;
		end else if (clk_en) begin
			din_s1_reg <= sram_din;
			din_s2_reg <= din_s1_reg;
		end
	end

	// Host reads barred in half duplex, whether scanning or not
	logic host_ok;
	logic wr_slot;
	logic rd_slot;
	always_comb begin
		host_ok = !(acc_mode == slbsc_pkg::SLBSC_M12_4) && !buf_empty && host_ready;
		wr_slot = (acc == slbsc_pkg::SLBSC_ACC_WR_HI) || (acc == slbsc_pkg::SLBSC_ACC_WR_LO);
		rd_slot = (acc == slbsc_pkg::SLBSC_ACC_HRD_HI) || (acc == slbsc_pkg::SLBSC_ACC_HRD_LO);
		// Odd phase continues a two-clock slot; single-clock gain and host reads each start one
		acc_first = !(phase_reg[0] && (wr_slot || acc_mode == slbsc_pkg::SLBSC_M8_4 ||
			acc_mode == slbsc_pkg::SLBSC_M12_4));
		pix_ready = clk_en && acc_first && !buf_full && !samp_hi_done_reg &&
			(acc == slbsc_pkg::SLBSC_ACC_WR_LO || acc == slbsc_pkg::SLBSC_ACC_WR_HI);
		do_access = (acc == slbsc_pkg::SLBSC_ACC_OFS) || (acc == slbsc_pkg::SLBSC_ACC_GAIN) ||
			(wr_slot && !buf_full && (samp_hi_done_reg || pix_valid)) ||
			(rd_slot && host_ok);
	end

	// Byte to write: high byte carries 4 MSBs, low byte 8 LSBs; the eight-bit schedules write the 8 MSBs
	always_comb begin
		if (acc == slbsc_pkg::SLBSC_ACC_WR_HI && !samp_hi_done_reg) begin
			wr_byte = {4'h0, pix_data[slbsc_pkg::SLBSC_SAMPLE_W-1 -: slbsc_pkg::SLBSC_HI_W]};
		end else if (samp_hi_done_reg) begin
			wr_byte = samp_reg[7:0];
		end else if (acc_mode == slbsc_pkg::SLBSC_M8_4 || acc_mode == slbsc_pkg::SLBSC_M8_8) begin
			wr_byte = pix_data[slbsc_pkg::SLBSC_SAMPLE_W-1 -: 8];
		end else begin
			wr_byte = pix_data[7:0];
		end
	end

	// Address for the current slot
	always_comb begin
		case (acc)
			slbsc_pkg::SLBSC_ACC_OFS: lin_addr = {1'b0, pix_index, 1'b0};
			slbsc_pkg::SLBSC_ACC_GAIN: lin_addr = {1'b0, pix_index, 1'b1};
			slbsc_pkg::SLBSC_ACC_WR_HI, slbsc_pkg::SLBSC_ACC_WR_LO: lin_addr = wptr_reg;
			default: lin_addr = rptr_reg;
		endcase
	end

	// Buffer pointers, fill count and the pending low byte
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wptr_reg <= slbsc_pkg::SLBSC_COEF_END_300;
			rptr_reg <= slbsc_pkg::SLBSC_COEF_END_300;
			count_reg <= 19'h00000;
			samp_reg <= 12'h000;
			samp_hi_done_reg <= 1'b0;
		end else if (clk_en) begin
			if (!scanning && buf_empty) begin
				wptr_reg <= base;
				rptr_reg <= base;
			end else if (acc_first && do_access) begin
				if (wr_slot) begin
					wptr_reg <= ptr_inc(wptr_reg, top, base);
					if (acc == slbsc_pkg::SLBSC_ACC_WR_HI && !samp_hi_done_reg) begin
						samp_reg <= pix_data;
						samp_hi_done_reg <= 1'b1;
					end else begin
						samp_hi_done_reg <= 1'b0;
					end
				end else if (rd_slot) begin
					rptr_reg <= ptr_inc(rptr_reg, top, base);
				end
			end
			if (acc_first && do_access && wr_slot && !(rd_slot)) begin
				count_reg <= count_reg + 19'h00001;
			end else if (acc_first && do_access && rd_slot) begin
				count_reg <= count_reg - 19'h00001;
			end
		end
	end

	// Full when another write would overtake unread data
	always_comb begin
		buf_full = (count_reg >= cap);
		buf_empty = (count_reg == 19'h00000);
	end

	// SRAM pins, registered; strobe only inside its own slot
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sram <= '{addr: 18'h00000, dout: 8'h00, dout_oe: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
				drive: 2'h0};
		end else if (clk_en) begin
			sram.drive <= drive_cfg;
			sram.addr <= lin_addr;
			case (mem_size)
				slbsc_pkg::SLBSC_MEM_64K:
					sram.addr[slbsc_pkg::SLBSC_A16] <= ~lin_addr[slbsc_pkg::SLBSC_A15];
				slbsc_pkg::SLBSC_MEM_128K:
					sram.addr[slbsc_pkg::SLBSC_A17] <= ~lin_addr[slbsc_pkg::SLBSC_A16];
				default: sram.addr <= lin_addr;
			endcase
			sram.dout <= wr_byte;
			sram.dout_oe <= do_access && wr_slot;
			// One strobe pulse per access, so a held slot never writes twice
			sram.wr_n <= !(acc_first && do_access && wr_slot);
			sram.rd_n <= !(acc_first && do_access && !wr_slot);
		end
	end

	// Capture read data three clocks after the strobe goes low
	slbsc_pkg::slbsc_acc_e acc_d1_reg;
	slbsc_pkg::slbsc_acc_e acc_d2_reg;
	slbsc_pkg::slbsc_acc_e acc_d3_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			acc_d1_reg <= slbsc_pkg::SLBSC_ACC_IDLE;
			acc_d2_reg <= slbsc_pkg::SLBSC_ACC_IDLE;
			acc_d3_reg <= slbsc_pkg::SLBSC_ACC_IDLE;
			coef_hi_reg <= 8'h00;
			coef <= '0;
			coef_valid <= 1'b0;
			host_data <= 8'h00;
			host_valid <= 1'b0;
		end else if (clk_en) begin
			acc_d1_reg <= (acc_first && do_access && !wr_slot) ? acc : slbsc_pkg::SLBSC_ACC_IDLE;
			acc_d2_reg <= acc_d1_reg;
			acc_d3_reg <= acc_d2_reg;
			coef_valid <= 1'b0;
			host_valid <= 1'b0;
			case (acc_d3_reg)
				slbsc_pkg::SLBSC_ACC_OFS: coef_hi_reg <= din_s2_reg;
				slbsc_pkg::SLBSC_ACC_GAIN: begin
					coef <= '{first: coef_hi_reg, second: din_s2_reg};
					coef_valid <= 1'b1;
				end
				slbsc_pkg::SLBSC_ACC_HRD_HI, slbsc_pkg::SLBSC_ACC_HRD_LO: begin
					host_data <= din_s2_reg;
					host_valid <= 1'b1;
				end
				default: ;
			endcase
		end
	end

endmodule

// ### core/slbsc_pkg.sv
// Package for the scanner line buffer SRAM controller
package slbsc_pkg;

	// Memory size settings
	typedef enum logic [1:0] {
		SLBSC_MEM_64K = 2'h0,
		SLBSC_MEM_128K = 2'h1,
		SLBSC_MEM_256K = 2'h2
	} slbsc_mem_e;

	// Access schedules
	typedef enum logic [1:0] {
		SLBSC_M8_4 = 2'h0,
		SLBSC_M8_8 = 2'h1,
		SLBSC_M12_4 = 2'h2,
		SLBSC_M12_8 = 2'h3
	} slbsc_mode_e;

	// Access kinds inside one pixel period
	typedef enum logic [2:0] {
		SLBSC_ACC_IDLE = 3'h0,
		SLBSC_ACC_OFS = 3'h1,
		SLBSC_ACC_GAIN = 3'h2,
		SLBSC_ACC_HRD_HI = 3'h3,
		SLBSC_ACC_HRD_LO = 3'h4,
		SLBSC_ACC_WR_HI = 3'h5,
		SLBSC_ACC_WR_LO = 3'h6
	} slbsc_acc_e;

	localparam int SLBSC_AW = 18;
	localparam int SLBSC_PIX_CLKS = 8;
	localparam logic [2:0] SLBSC_PHASE_LAST = 3'h7;
	localparam int SLBSC_SAMPLE_W = 12;
	localparam int SLBSC_HI_W = 4;
	// Coefficient region ends: 16 KB for 300 dpi, 32 KB for 600 dpi
	localparam logic [17:0] SLBSC_COEF_END_300 = 18'h04000;
	localparam logic [17:0] SLBSC_COEF_END_600 = 18'h08000;
	// Top address for each size setting
	localparam logic [17:0] SLBSC_TOP_64K = 18'h0ffff;
	localparam logic [17:0] SLBSC_TOP_128K = 18'h1ffff;
	localparam logic [17:0] SLBSC_TOP_256K = 18'h3ffff;
	localparam int SLBSC_A15 = 15;
	localparam int SLBSC_A16 = 16;
	localparam int SLBSC_A17 = 17;

	// SRAM pin group
	typedef struct packed {
		logic [17:0] addr;
		logic [7:0] dout;
		logic dout_oe;
		logic rd_n;
		logic wr_n;
		logic [1:0] drive;
	} slbsc_sram_s;

	// Coefficient word for one pixel
	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
	} slbsc_coef_s;

endpackage

// ### tb/slbsc_ctrl_properties.sv
// Port-level checks for the SRAM controller
`timescale 1ns/1ps
module slbsc_ctrl_properties (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Configuration and handshakes
	input wire slbsc_pkg::slbsc_mem_e mem_size,
	input wire slbsc_pkg::slbsc_mode_e acc_mode,
	input wire logic [1:0] drive_cfg,
	input wire logic pix_valid,
	input wire logic pix_ready,
	input wire logic coef_valid,
	input wire logic host_valid,
	input wire logic buf_full,
	input wire logic buf_empty,
	// SRAM pins
	input wire slbsc_pkg::slbsc_sram_s sram
);
	logic acc;
	logic take;
	// Address pins only matter while a strobe is low
	assign acc = !sram.rd_n || !sram.wr_n;
	assign take = pix_ready && pix_valid;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Seven quiet cycles, then the next word
	sequence s_quiet;
		!coef_valid [*7];
	endsequence
	sequence s_next_word;
		s_quiet ##1 coef_valid;
	endsequence
	a_coef_per_pixel: assert property (
		coef_valid |=> s_next_word) else $error("coefficient word missed its period");
	a_low_size_sel: assert property (
		acc && mem_size == slbsc_pkg::SLBSC_MEM_64K |-> sram.addr[16] != sram.addr[15])
		else $error("low size select bits not inverse");
	a_mid_size_sel: assert property (
		acc && mem_size == slbsc_pkg::SLBSC_MEM_128K |-> sram.addr[17] != sram.addr[16])
		else $error("mid size select bits not inverse");
	a_one_strobe: assert property (
		!(!sram.rd_n && !sram.wr_n)) else $error("read and write strobes overlap");
	a_write_short: assert property (
		!sram.wr_n |=> sram.wr_n) else $error("write strobe longer than one cycle");
	a_write_taken: assert property (
		take && !buf_full |=> !sram.wr_n && sram.dout_oe) else $error("taken pixel not written");
	a_full_blocks: assert property (
		pix_valid && buf_full |=> sram.wr_n) else $error("write while buffer full");
	a_flags_apart: assert property (
		!(buf_full && buf_empty)) else $error("full and empty together");
	a_half_duplex_host: assert property (
		acc_mode == slbsc_pkg::SLBSC_M12_4 |-> !host_valid) else $error("host byte in half duplex");
	a_drive_follow: assert property (
		$stable(drive_cfg) [*2] |-> sram.drive == drive_cfg) else $error("drive setting not applied");
	a_reset_idle: assert property (disable iff (1'b0)
		rst |=> sram.rd_n && sram.wr_n && !sram.dout_oe && !coef_valid && !host_valid)
		else $error("outputs not idle after reset");
endmodule
bind slbsc_ctrl slbsc_ctrl_properties u_props (.clk_sys(clk_sys), .rst(rst), .mem_size(mem_size),
	.acc_mode(acc_mode), .drive_cfg(drive_cfg), .pix_valid(pix_valid), .pix_ready(pix_ready),
	.coef_valid(coef_valid), .host_valid(host_valid), .buf_full(buf_full),
	.buf_empty(buf_empty), .sram(sram));

// ### tb/slbsc_sram_model.sv
// Behavioural byte-wide asynchronous SRAM on the controller pins
`timescale 1ns/1ps
module slbsc_sram_model (
	// Clock used to capture writes and toggle the undriven bus
	input wire logic clk_sys,
	// Pins
	input wire slbsc_pkg::slbsc_mem_e mem_size,
	input wire slbsc_pkg::slbsc_sram_s sram,
	output logic [7:0] sram_din
);
	logic [7:0] mem [int];
	logic [7:0] wq [$];
	logic [17:0] eff;
	logic tgl = 1'b0;
	// Two half parts selected by the top bits look like one array
	always_comb begin
		case (mem_size)
			slbsc_pkg::SLBSC_MEM_64K: eff = {2'h0, sram.addr[15:0]};
			slbsc_pkg::SLBSC_MEM_128K: eff = {1'h0, sram.addr[16:0]};
			default: eff = sram.addr;
		endcase
	end
	// Undriven bus toggles so stale bytes never look valid
	always @* begin
		if (!sram.rd_n)
			sram_din = mem.exists(eff) ? mem[eff] : (eff[7:0] ^ eff[15:8]);
		else
			sram_din = {8{tgl}} ^ 8'h5a;
	end
	// Store and log each byte written
	always @(posedge clk_sys) begin
		tgl <= ~tgl;
		if (!sram.wr_n) begin
			mem[eff] = sram.dout;
			wq.push_back(sram.dout);
		end
	end
endmodule

// ### tb/slbsc_ctrl_tb.sv
// Self-checking bench for the SRAM controller
`timescale 1ns/1ps
module slbsc_ctrl_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	slbsc_pkg::slbsc_mem_e mem_size = slbsc_pkg::SLBSC_MEM_64K;
	slbsc_pkg::slbsc_mode_e acc_mode = slbsc_pkg::SLBSC_M8_8;
	logic dpi_600 = 1'b0;
	logic [1:0] drive_cfg = 2'h0;
	logic scanning = 1'b0;
	logic [15:0] pix_index = 16'h0000;
	logic [11:0] pix_data = 12'h000;
	logic pix_valid = 1'b0;
	logic host_ready = 1'b0;
	slbsc_pkg::slbsc_coef_s coef;
	slbsc_pkg::slbsc_sram_s sram;
	logic coef_valid, pix_ready, host_valid, buf_full, buf_empty;
	logic [7:0] host_data, sram_din;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #4 clk_sys = ~clk_sys;
	slbsc_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .mem_size(mem_size),
		.acc_mode(acc_mode), .dpi_600(dpi_600), .drive_cfg(drive_cfg), .scanning(scanning),
		.pix_index(pix_index), .coef(coef), .coef_valid(coef_valid), .pix_data(pix_data),
		.pix_valid(pix_valid), .pix_ready(pix_ready), .host_data(host_data),
		.host_valid(host_valid), .host_ready(host_ready), .buf_full(buf_full),
		.buf_empty(buf_empty), .sram(sram), .sram_din(sram_din));
	slbsc_sram_model u_sram (.clk_sys(clk_sys), .mem_size(mem_size), .sram(sram),
		.sram_din(sram_din));
	// Hang guard, well above the fewer than one thousand cycles needed
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			$display("[FAIL] %0t timeout", $time);
			end_sim();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Schedule and memory size only change under reset
	task automatic reconf(input slbsc_pkg::slbsc_mode_e m, input slbsc_pkg::slbsc_mem_e s);
		@(negedge clk_sys);
		rst = 1'b1;
		acc_mode = m;
		mem_size = s;
		u_sram.wq.delete();
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
	endtask
	// Coefficient word for every schedule, size and drive setting
	task automatic t_coef();
		logic [17:0] a;
		for (int k = 0; k < 4; k++) begin
			pix_index = 16'h0123 + 16'(k);
			drive_cfg = 2'(k);
			reconf(slbsc_pkg::slbsc_mode_e'(k), slbsc_pkg::slbsc_mem_e'(k % 3));
			a = {1'b0, pix_index, 1'b0};
			for (int i = 0; i < 40 && coef_valid !== 1'b1; i++)
				@(negedge clk_sys);
			chk({15'h0, coef_valid}, 16'h0001);
			chk(coef, {a[7:0] ^ a[15:8], a[7:0] ^ a[15:8] ^ 8'h01});
			chk({14'h0, sram.drive}, {14'h0, drive_cfg});
		end
		$display("test coef done");
	endtask
	// Sample bytes as stored in memory
	task automatic t_write(input slbsc_pkg::slbsc_mode_e m, input logic [15:0] exp);
		reconf(m, slbsc_pkg::SLBSC_MEM_128K);
		scanning = 1'b1;
		pix_data = 12'habc;
		pix_valid = 1'b1;
		repeat (80) @(negedge clk_sys);
		pix_valid = 1'b0;
		chk({u_sram.wq[0], u_sram.wq[1]}, exp);
		$display("test write done");
	endtask
	// Host bytes in one pixel period after a fill
	task automatic t_drain(input slbsc_pkg::slbsc_mode_e m, input logic [15:0] w, input int nx);
		int n;
		n = 0;
		t_write(m, w);
		host_ready = 1'b1;
		for (int i = 0; i < 40 && host_valid !== 1'b1; i++)
			@(negedge clk_sys);
		repeat (8) begin
			@(negedge clk_sys);
			if (host_valid === 1'b1) begin
				n++;
				chk({8'h0, host_data}, 16'h00ab);
			end
		end
		chk(16'(n), 16'(nx));
		repeat (100) @(negedge clk_sys);
		if (nx > 0)
			chk({15'h0, buf_empty}, 16'h0001);
		host_ready = 1'b0;
		$display("test drain done");
	endtask
	initial begin
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		t_coef();
		t_drain(slbsc_pkg::SLBSC_M8_4, 16'habab, 1);
		t_drain(slbsc_pkg::SLBSC_M8_8, 16'habab, 4);
		t_drain(slbsc_pkg::SLBSC_M12_4, 16'h0abc, 0);
		t_write(slbsc_pkg::SLBSC_M12_8, 16'h0abc);
		end_sim();
	end
endmodule
